//--- verilog/rtc_time_of_day_alarm.v
// Purpose: Time-of-day alarm logic of a real-time clock with an AXI4-Lite register port.
// Assumes: One clock core_clk at 100 MHz; the 1 Hz tick comes from an internal divider.
// Notes: Alarm registers have no reset value; time count runs in packed BCD, 24-hour hours.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "rtc_alarm_defines.vh"

module rtc_time_of_day_alarm #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins
  output wire irqOrSquareWavePin_n,
  output wire irq
);

  reg [7:0] timeSec_reg, timeMin_reg, timeHour_reg, timeDay_reg;
  // Alarm storage has no reset: contents are undefined until written.
  reg [7:0] alm1Sec_reg, alm1Min_reg, alm1Hour_reg, alm1Day_reg;
  reg [7:0] alm2Min_reg, alm2Hour_reg, alm2Day_reg;
  reg [7:0] control_reg;
  reg firstAlarmMatchFlag_reg, secondAlarmMatchFlag_reg;
  reg [1:0] irqStat_reg, irqMask_reg;
  reg [31:0] divCnt_reg;
  reg tick_reg, sqw_reg;

  reg [7:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg awHeld_reg, wHeld_reg;

  wire firstAlarmIrqEnable = control_reg[`CTL_A1_IE_BIT];
  wire secondAlarmIrqEnable = control_reg[`CTL_A2_IE_BIT];
  wire oscRun = ~control_reg[`CTL_OSC_OFF_BIT];
  wire intMode = control_reg[`CTL_INTCN_BIT];

  function [7:0] bcdInc;
    input [7:0] v;
    input [7:0] maxV;
    begin
      if (v == maxV) begin
        bcdInc = 8'h00;
      end else if (v[3:0] == 4'h9) begin
        bcdInc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdInc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Decides whether an alarm compares against the time; used for both channels.
  function almHit;
    input [7:0] aSec, aMin, aHour, aDay;
    input [7:0] tSec, tMin, tHour, tDay;
    begin
      almHit = (aSec == tSec) && (aMin == tMin) && (aHour == tHour) &&
               (aDay[`DAY_MASK_BIT] || (aDay == tDay));
    end
  endfunction

  // 1 Hz tick and square wave from the core clock.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
      sqw_reg <= 1'b0;
    end else if (oscRun) begin
      tick_reg <= 1'b0;
      if (divCnt_reg == TICK_CYCLES - 1) begin
        divCnt_reg <= 32'h00000000;
        tick_reg <= 1'b1;
        sqw_reg <= 1'b0;
      end else begin
        divCnt_reg <= divCnt_reg + 32'h00000001;
        if (divCnt_reg == TICK_CYCLES / 2 - 1) begin
          sqw_reg <= 1'b1;
        end
      end
    end else begin
      tick_reg <= 1'b0;
    end
  end

  // Write channel: address and data accepted independently, response after both.
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  wire [7:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire haveAw = awHeld_reg | (s_axi_awvalid & s_axi_awready);
  wire haveW = wHeld_reg | (s_axi_wvalid & s_axi_wready);
  wire doWrite = haveAw & haveW;
  wire wrLane = wrStrb[0];

  function addrKnown;
    input [7:0] a;
    begin
      addrKnown = (a[1:0] == 2'b00) && (a <= `OFS_IRQ_MASK);
    end
  endfunction

  wire wrStatus = doWrite && wrLane && wrAddr == `OFS_STATUS;
  wire wrTimeSec = doWrite && wrLane && wrAddr == `OFS_TIME_SEC;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addrKnown(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  // Alarm storage is plain read/write memory whatever the enable state.
  always @(posedge core_clk) begin
    if (doWrite && wrLane) begin
      case (wrAddr)
        `OFS_ALM1_SEC: alm1Sec_reg <= wrData[7:0];
        `OFS_ALM1_MIN: alm1Min_reg <= wrData[7:0];
        `OFS_ALM1_HOUR: alm1Hour_reg <= wrData[7:0];
        `OFS_ALM1_DAY: alm1Day_reg <= wrData[7:0];
        `OFS_ALM2_MIN: alm2Min_reg <= wrData[7:0];
        `OFS_ALM2_HOUR: alm2Hour_reg <= wrData[7:0];
        `OFS_ALM2_DAY: alm2Day_reg <= wrData[7:0];
        default: ;
      endcase
    end
  end

  // Time count; a host write wins over the tick for the written field.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeSec_reg <= 8'h00;
      timeMin_reg <= 8'h00;
      timeHour_reg <= 8'h00;
      timeDay_reg <= 8'h01;
    end else begin
      if (tick_reg) begin
        timeSec_reg <= bcdInc(timeSec_reg, 8'h59);
        if (timeSec_reg == 8'h59) begin
          timeMin_reg <= bcdInc(timeMin_reg, 8'h59);
          if (timeMin_reg == 8'h59) begin
            timeHour_reg <= bcdInc(timeHour_reg, 8'h23);
            if (timeHour_reg == 8'h23) begin
              timeDay_reg <= (timeDay_reg == 8'h31) ? 8'h01 : bcdInc(timeDay_reg, 8'h31);
            end
          end
        end
      end
      if (wrTimeSec) begin
        timeSec_reg <= wrData[7:0];
      end
      if (doWrite && wrLane && wrAddr == `OFS_TIME_MIN) begin
        timeMin_reg <= wrData[7:0];
      end
      if (doWrite && wrLane && wrAddr == `OFS_TIME_HOUR) begin
        timeHour_reg <= wrData[7:0];
      end
      if (doWrite && wrLane && wrAddr == `OFS_TIME_DAY) begin
        timeDay_reg <= wrData[7:0];
      end
    end
  end

  // Compare right after each tick updated the count, so one match per second.
  reg cmpPending_reg;
  wire hit1 = cmpPending_reg && almHit(alm1Sec_reg, alm1Min_reg, alm1Hour_reg, alm1Day_reg,
    timeSec_reg, timeMin_reg, timeHour_reg, timeDay_reg);
  wire hit2 = cmpPending_reg && almHit(8'h00, alm2Min_reg, alm2Hour_reg, alm2Day_reg,
    timeSec_reg, timeMin_reg, timeHour_reg, timeDay_reg);

  wire rdIrqStat;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpPending_reg <= 1'b0;
      control_reg <= `CTL_RESET;
      firstAlarmMatchFlag_reg <= 1'b0;
      secondAlarmMatchFlag_reg <= 1'b0;
      irqStat_reg <= 2'b00;
      irqMask_reg <= 2'b00;
    end else begin
      cmpPending_reg <= tick_reg;
      if (doWrite && wrLane && wrAddr == `OFS_CONTROL) begin
        control_reg <= wrData[7:0];
      end
      if (doWrite && wrLane && wrAddr == `OFS_IRQ_MASK) begin
        irqMask_reg <= wrData[1:0];
      end
      // Software writes zero to clear a flag; a match in the same cycle wins.
      if (wrStatus && !wrData[0]) begin
        firstAlarmMatchFlag_reg <= 1'b0;
      end
      if (wrStatus && !wrData[1]) begin
        secondAlarmMatchFlag_reg <= 1'b0;
      end
      if (hit1) begin
        firstAlarmMatchFlag_reg <= 1'b1;
      end
      if (hit2) begin
        secondAlarmMatchFlag_reg <= 1'b1;
      end
      irqStat_reg <= (rdIrqStat ? 2'b00 : irqStat_reg) | {hit2, hit1};
    end
  end

  // With INTCN set, pin low while a flag and its enable are both set, else idle high; with INTCN clear, square wave.
  wire alarmActive = (firstAlarmMatchFlag_reg & firstAlarmIrqEnable) |
                     (secondAlarmMatchFlag_reg & secondAlarmIrqEnable);
  assign irqOrSquareWavePin_n = intMode ? ~alarmActive : sqw_reg;
  assign irq = |(irqStat_reg & irqMask_reg);

  // Read channel: one read at a time, data registered.
  assign s_axi_arready = ~s_axi_rvalid;
  wire doRead = s_axi_arvalid & s_axi_arready;
  assign rdIrqStat = doRead && s_axi_araddr == `OFS_IRQ_STAT;

  reg [7:0] rdByte;
  always @* begin
    rdByte = 8'h00;
    case (s_axi_araddr)
      `OFS_TIME_SEC: rdByte = timeSec_reg;
      `OFS_TIME_MIN: rdByte = timeMin_reg;
      `OFS_TIME_HOUR: rdByte = timeHour_reg;
      `OFS_TIME_DAY: rdByte = timeDay_reg;
      `OFS_ALM1_SEC: rdByte = alm1Sec_reg;
      `OFS_ALM1_MIN: rdByte = alm1Min_reg;
      `OFS_ALM1_HOUR: rdByte = alm1Hour_reg;
      `OFS_ALM1_DAY: rdByte = alm1Day_reg;
      `OFS_ALM2_MIN: rdByte = alm2Min_reg;
      `OFS_ALM2_HOUR: rdByte = alm2Hour_reg;
      `OFS_ALM2_DAY: rdByte = alm2Day_reg;
      `OFS_CONTROL: rdByte = control_reg;
      `OFS_STATUS: rdByte = {6'h00, secondAlarmMatchFlag_reg, firstAlarmMatchFlag_reg};
      `OFS_IRQ_STAT: rdByte = {6'h00, irqStat_reg};
      `OFS_IRQ_MASK: rdByte = {6'h00, irqMask_reg};
      default: rdByte = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= addrKnown(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule // rtc_time_of_day_alarm

//--- shared/rtc_alarm_defines.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the alarm block.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes: Alarm values are packed BCD.
`ifndef RTC_ALARM_DEFINES_VH
`define RTC_ALARM_DEFINES_VH

`define OFS_TIME_SEC 8'h00
`define OFS_TIME_MIN 8'h04
`define OFS_TIME_HOUR 8'h08
`define OFS_TIME_DAY 8'h0C
`define OFS_ALM1_SEC 8'h10
`define OFS_ALM1_MIN 8'h14
`define OFS_ALM1_HOUR 8'h18
`define OFS_ALM1_DAY 8'h1C
`define OFS_ALM2_MIN 8'h20
`define OFS_ALM2_HOUR 8'h24
`define OFS_ALM2_DAY 8'h28
`define OFS_CONTROL 8'h2C
`define OFS_STATUS 8'h30
`define OFS_IRQ_STAT 8'h34
`define OFS_IRQ_MASK 8'h38

`define CTL_A1_IE_BIT 0
`define CTL_A2_IE_BIT 1
`define CTL_INTCN_BIT 2
`define CTL_OSC_OFF_BIT 7
`define CTL_RESET 8'h04
`define DAY_MASK_BIT 7
`define STATUS_RESET 8'h00

`define CLK_HZ 100000000
`define TICK_HZ 1
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define HALF_TICK_CYCLES (`TICK_CYCLES / 2)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verif/rtc_alarm_asserts.sv
// Purpose: Port checks of the alarm block.
// Assumes: The host offers write address and data in the same cycle.
// Notes: A shadow of control follows bus writes, so a missed write is not seen.
`timescale 1ns/1ps
`include "rtc_alarm_defines.vh"
module rtc_alarm_checker (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Write bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  // Pin
  input wire irqOrSquareWavePin_n
);
  wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire pin = irqOrSquareWavePin_n;
  reg [7:0] ctlSh;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ctlSh <= `CTL_RESET;
    else if (wrHs && s_axi_awaddr == `OFS_CONTROL) ctlSh <= s_axi_wdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  pin_reset_high_a: assert property ($rose(rst_n) |-> pin)
    else $error("pin low after reset");
  alarms_off_high_a: assert property (ctlSh == 8'h04 |-> pin)
    else $error("pin low with alarms off");
  low_needs_enable_a: assert property (ctlSh[2] && !pin |-> ctlSh[1:0] != 2'h0)
    else $error("pin low without enable");
  clear_releases_a: assert property (wrHs && s_axi_awaddr == `OFS_STATUS &&
    s_axi_wdata[7:0] == 8'h00 && ctlSh[2] |=> pin) else $error("pin low after flag clear");
  low_holds_a: assert property (ctlSh[2] && !pin && !wrHs |=> !pin)
    else $error("pin released without write");
  write_answer_a: assert property (wrHs |=> s_axi_bvalid)
    else $error("no write response");
  busy_refuse_a: assert property (wrHs |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  unmapped_err_a: assert property (wrHs && s_axi_awaddr == 8'h3C |=> s_axi_bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule // rtc_alarm_checker
bind rtc_time_of_day_alarm rtc_alarm_checker i_rtc_alarm_checker (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .irqOrSquareWavePin_n(irqOrSquareWavePin_n)
);

//--- verif/rtc_host_model.sv
// Purpose: Host processor model that reaches the alarm registers.
// Assumes: Caller enters a task just after a rising edge.
// Notes: Each task ends one edge after the answer, so strobes never change twice at once.
`timescale 1ns/1ps
module rtc_host_model (
  // Clock
  input wire core_clk,
  // Write channels
  output reg [7:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  // Read channels
  output reg [7:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  end
  task wr(input [7:0] a, input [7:0] d, output [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
    end
  endtask
endmodule // rtc_host_model

//--- verif/rtc_time_of_day_alarm_bench.sv
// Purpose: Register-level tests of the alarm block.
// Assumes: A tick every 20 cycles keeps the waits short.
// Notes: Time is only set while both alarms are off.
`timescale 1ns/1ps
`include "rtc_alarm_defines.vh"
module rtc_time_of_day_alarm_bench;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irqOrSquareWavePin_n, irq;
  integer error_cnt = 0;
  integer cmp_count = 0;
  integer k;
  reg [7:0] d;
  reg [1:0] r;
  rtc_time_of_day_alarm #(.TICK_CYCLES(20)) i_rtc_time_of_day_alarm (.*);
  rtc_host_model i_rtc_host_model (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task chk8(input string n, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task w(input [7:0] a, input [7:0] v, input [1:0] er);
    begin
      i_rtc_host_model.wr(a, v, r);
      chk8("bresp", {6'h00, er}, {6'h00, r});
    end
  endtask
  task rc(input [7:0] a, input [7:0] e, input [1:0] er);
    begin
      i_rtc_host_model.rd(a, d, r);
      chk8("rdata", e, d);
      chk8("rresp", {6'h00, er}, {6'h00, r});
    end
  endtask
  task waitPin(input e);
    begin
      k = 0;
      while (irqOrSquareWavePin_n !== e && k < 100) begin
        @(posedge core_clk);
        k = k + 1;
      end
      chk8("pin", {7'h00, e}, {7'h00, irqOrSquareWavePin_n});
    end
  endtask
  task arm(input [7:0] ctl);
    begin
      w(`OFS_CONTROL, 8'h04, 2'h0);
      w(`OFS_TIME_SEC, 8'h58, 2'h0);
      w(`OFS_TIME_MIN, 8'h29, 2'h0);
      w(`OFS_TIME_HOUR, 8'h05, 2'h0);
      w(`OFS_STATUS, 8'h00, 2'h0);
      w(`OFS_CONTROL, ctl, 2'h0);
    end
  endtask
  task test_done;
    begin
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Alarm storage has no reset value, so alarm 2 is loaded before the first compare runs.
    w(`OFS_ALM2_MIN, 8'h00, 2'h0);
    w(`OFS_ALM2_HOUR, 8'h00, 2'h0);
    w(`OFS_ALM2_DAY, 8'h00, 2'h0);
    rc(`OFS_CONTROL, 8'h04, 2'h0);
    rc(`OFS_STATUS, 8'h00, 2'h0);
    w(`OFS_ALM1_MIN, 8'hA5, 2'h0);
    rc(`OFS_ALM1_MIN, 8'hA5, 2'h0);
    w(8'h3C, 8'h5A, `RESP_SLVERR);
    rc(8'h3C, 8'h00, `RESP_SLVERR);
    w(`OFS_ALM1_SEC, 8'h00, 2'h0);
    w(`OFS_ALM1_MIN, 8'h30, 2'h0);
    w(`OFS_ALM1_HOUR, 8'h05, 2'h0);
    w(`OFS_ALM1_DAY, 8'h80, 2'h0);
    w(`OFS_IRQ_MASK, 8'h00, 2'h0);
    arm(8'h04);
    repeat (60) @(posedge core_clk);
    chk8("pin", 8'h01, {7'h00, irqOrSquareWavePin_n});
    chk8("irq", 8'h00, {7'h00, irq});
    rc(`OFS_STATUS, 8'h01, 2'h0);
    rc(`OFS_IRQ_STAT, 8'h01, 2'h0);
    rc(`OFS_IRQ_STAT, 8'h00, 2'h0);
    w(`OFS_IRQ_MASK, 8'h01, 2'h0);
    arm(8'h05);
    waitPin(1'b0);
    chk8("irq", 8'h01, {7'h00, irq});
    rc(`OFS_IRQ_STAT, 8'h01, 2'h0);
    chk8("irq", 8'h00, {7'h00, irq});
    w(`OFS_STATUS, 8'h00, 2'h0);
    waitPin(1'b1);
    rc(`OFS_CONTROL, 8'h05, 2'h0);
    arm(8'h05);
    waitPin(1'b0);
    w(`OFS_CONTROL, 8'h04, 2'h0);
    chk8("pin", 8'h01, {7'h00, irqOrSquareWavePin_n});
    repeat (60) @(posedge core_clk);
    chk8("pin", 8'h01, {7'h00, irqOrSquareWavePin_n});
    rc(`OFS_STATUS, 8'h01, 2'h0);
    rc(`OFS_ALM1_HOUR, 8'h05, 2'h0);
    w(`OFS_ALM1_DAY, 8'h00, 2'h0);
    w(`OFS_ALM2_MIN, 8'h30, 2'h0);
    w(`OFS_ALM2_HOUR, 8'h05, 2'h0);
    w(`OFS_ALM2_DAY, 8'h80, 2'h0);
    arm(8'h06);
    waitPin(1'b0);
    rc(`OFS_STATUS, 8'h02, 2'h0);
    w(`OFS_STATUS, 8'h01, 2'h0);
    waitPin(1'b1);
    rc(`OFS_STATUS, 8'h00, 2'h0);
    w(`OFS_CONTROL, 8'h00, 2'h0);
    waitPin(1'b1);
    waitPin(1'b0);
    waitPin(1'b1);
    w(`OFS_CONTROL, 8'h84, 2'h0);
    w(`OFS_TIME_SEC, 8'h12, 2'h0);
    repeat (60) @(posedge core_clk);
    rc(`OFS_TIME_SEC, 8'h12, 2'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rc(`OFS_CONTROL, 8'h04, 2'h0);
    rc(`OFS_STATUS, 8'h00, 2'h0);
    rc(`OFS_ALM2_HOUR, 8'h05, 2'h0);
    rc(`OFS_TIME_SEC, 8'h00, 2'h0);
    test_done;
  end
endmodule // rtc_time_of_day_alarm_bench
